// *** core/tcls_defs.vh ***
// register offsets, field positions, reset values and encodings for the trigger count block
`ifndef TCLS_DEFS_VH
`define TCLS_DEFS_VH
`define TCLS_OFF_CHUNK_CTRL 12'h000
`define TCLS_OFF_COUNT_CFG 12'h004
`define TCLS_OFF_COUNT_CMD 12'h008
`define TCLS_OFF_COUNT_VAL 12'h00c
`define TCLS_OFF_SNAP_VAL 12'h010
`define TCLS_OFF_FRAME_VAL 12'h014
`define TCLS_OFF_STATUS 12'h018
`define TCLS_BIT_MASTER 0
`define TCLS_BIT_PICK_LO 4
`define TCLS_BIT_PICK_HI 5
`define TCLS_BIT_FSWITCH 8
`define TCLS_BIT_TRIG_EN 16
`define TCLS_BIT_ORIGIN_LO 0
`define TCLS_BIT_ORIGIN_HI 1
`define TCLS_BIT_SLOT_LO 4
`define TCLS_BIT_SLOT_HI 5
`define TCLS_BIT_EVENT_LO 8
`define TCLS_BIT_EVENT_HI 9
`define TCLS_BIT_CLEAR_CMD 0
`define TCLS_PICK_TRIG 2'h0
`define TCLS_PICK_SNAP 2'h1
`define TCLS_ORIGIN_OFF 2'h0
`define TCLS_ORIGIN_PIN 2'h1
`define TCLS_ORIGIN_SW 2'h2
`define TCLS_SLOT_TRIG 2'h1
`define TCLS_SLOT_FRAME 2'h2
`define TCLS_EVT_TRIG 2'h0
`define TCLS_EVT_BEGIN 2'h1
`define TCLS_TRIG_START 32'h00000001
`define TCLS_FRAME_START 32'h00000000
`define TCLS_TAG_TRIG 2'h0
`define TCLS_TAG_SNAP 2'h1
`endif

// *** core/tcls_trigger_chunks.v ***
// trigger counter, line snapshot and chunk field source with apb registers
`timescale 1ns/1ps
`include "tcls_defs.vh"
module tcls_trigger_chunks #(
  parameter N_IN = 1,
  parameter N_OUT = 1,
  parameter N_GPIO = 0,
  parameter [31:0] IN_BIT0 = 32'h00000000,
  parameter [31:0] OUT_BIT0 = 32'h00000001,
  parameter [31:0] GPIO_BIT0 = 32'h00000002
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  input wire acquisition_trigger_event,
  input wire acquisition_begin_event,
  input wire first_input_pin,
  input wire [N_IN-1:0] in_lines,
  input wire [N_OUT-1:0] out_lines,
  input wire [N_GPIO > 0 ? N_GPIO-1 : 0:0] gpio_lines,
  input wire image_done,
  output wire field_valid,
  input wire field_ready,
  output wire [31:0] field_data,
  output wire [1:0] field_tag
);

////////////////////////////////////////////////////////////////////////////////
// register state

reg chunk_master_switch_reg;
reg [1:0] chunk_field_pick_reg;
reg trig_field_en_reg;
reg snap_field_en_reg;
reg trig_enable_reg;
reg [1:0] count_clear_origin_reg;
reg [1:0] count_slot_pick_reg;
reg [1:0] count_event_origin_reg;
reg [31:0] trigger_count_reg;
reg [31:0] frame_count_reg;
reg [31:0] line_snapshot_reg;
reg pin_prev_reg;
reg dropped_reg;

wire wr_en = psel & penable & pwrite;
wire rd_en = psel & penable & ~pwrite;
wire [11:0] word_addr = {paddr[11:2], 2'b00};
wire addr_ok = (word_addr <= `TCLS_OFF_STATUS) & (paddr[1:0] == 2'b00);
wire wr_lo = wr_en & pstrb[0] & addr_ok;
wire wr_b1 = wr_en & pstrb[1] & addr_ok;
wire wr_b2 = wr_en & pstrb[2] & addr_ok;

// zero wait states: every register answers in its first access cycle
assign pready = 1'b1;
assign pslverr = psel & penable & ~addr_ok;

////////////////////////////////////////////////////////////////////////////////
// line snapshot word

function [31:0] place_bits;
  input [31:0] levels;
  input integer count;
  input [31:0] base;
  integer i;
  begin
    place_bits = 32'h00000000;
    for (i = 0; i < 32; i = i + 1) begin
      if (i < count && base + i < 32)
        place_bits[base + i] = levels[i];
    end
  end
endfunction

wire [31:0] in_pad = {{(32-N_IN){1'b0}}, in_lines};
wire [31:0] out_pad = {{(32-N_OUT){1'b0}}, out_lines};
// the gpio port keeps one bit when the variant has no gpio lines
localparam GPIO_W = (N_GPIO > 0) ? N_GPIO : 1;
wire [31:0] gpio_pad = {{(32-GPIO_W){1'b0}}, gpio_lines};
// unassigned positions stay zero since only placed bits are ored in
wire [31:0] snap_now = place_bits(in_pad, N_IN, IN_BIT0) |
  place_bits(out_pad, N_OUT, OUT_BIT0) |
  place_bits(gpio_pad, N_GPIO, GPIO_BIT0);

////////////////////////////////////////////////////////////////////////////////
// clear sources

// pin clear acts on the rising edge so a held level does not freeze the count
wire pin_rise = first_input_pin & ~pin_prev_reg;
wire sw_cmd = wr_lo & (word_addr == `TCLS_OFF_COUNT_CMD) & pwdata[`TCLS_BIT_CLEAR_CMD];
// the software clear acts only while slot one is set up with its trigger event
wire slot_is_trig = (count_slot_pick_reg == `TCLS_SLOT_TRIG) &
  (count_event_origin_reg == `TCLS_EVT_TRIG);
wire clear_trig = ((count_clear_origin_reg == `TCLS_ORIGIN_PIN) & pin_rise) |
  ((count_clear_origin_reg == `TCLS_ORIGIN_SW) & sw_cmd & slot_is_trig);
wire trig_take = acquisition_trigger_event & trig_enable_reg;
// the wrap to zero is explicit rather than left to the adder width
wire count_at_max = (trigger_count_reg == 32'hffffffff);

always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    pin_prev_reg <= 1'b0;
  end else begin
    pin_prev_reg <= first_input_pin;
  end
end

////////////////////////////////////////////////////////////////////////////////
// counters and snapshot

always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    trigger_count_reg <= 32'h00000000;
    frame_count_reg <= `TCLS_FRAME_START;
    line_snapshot_reg <= 32'h00000000;
  end else begin
    // a trigger in the same cycle as a clear is counted after the clear
    if (clear_trig && trig_take)
      trigger_count_reg <= `TCLS_TRIG_START;
    else if (clear_trig)
      trigger_count_reg <= 32'h00000000;
    else if (trig_take && count_at_max)
      trigger_count_reg <= 32'h00000000;
    else if (trig_take)
      trigger_count_reg <= trigger_count_reg + 32'h00000001;
    if (acquisition_begin_event)
      frame_count_reg <= frame_count_reg + 32'h00000001;
    if (trig_take)
      line_snapshot_reg <= snap_now;
  end
end

////////////////////////////////////////////////////////////////////////////////
// control registers

// picked field decode, shared by the enable write and the read back
function [1:0] pick_decode;
  input [1:0] pick;
  begin
    pick_decode = {pick == `TCLS_PICK_SNAP, pick == `TCLS_PICK_TRIG};
  end
endfunction

wire [1:0] pick_dec = pick_decode(chunk_field_pick_reg);

always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    chunk_master_switch_reg <= 1'b0;
    chunk_field_pick_reg <= `TCLS_PICK_TRIG;
    trig_field_en_reg <= 1'b0;
    snap_field_en_reg <= 1'b0;
    trig_enable_reg <= 1'b1;
    count_clear_origin_reg <= `TCLS_ORIGIN_OFF;
    count_slot_pick_reg <= `TCLS_SLOT_TRIG;
    count_event_origin_reg <= `TCLS_EVT_TRIG;
  end else begin
    if (wr_lo && word_addr == `TCLS_OFF_CHUNK_CTRL) begin
      chunk_master_switch_reg <= pwdata[`TCLS_BIT_MASTER];
      chunk_field_pick_reg <= pwdata[`TCLS_BIT_PICK_HI:`TCLS_BIT_PICK_LO];
      if (!pwdata[`TCLS_BIT_MASTER]) begin
        trig_field_en_reg <= 1'b0;
        snap_field_en_reg <= 1'b0;
      end
    end
    // the switch write uses the pick already stored, so pick first then enable
    if (wr_b1 && word_addr == `TCLS_OFF_CHUNK_CTRL && chunk_master_switch_reg &&
        (!wr_lo || pwdata[`TCLS_BIT_MASTER])) begin
      if (pick_dec[0])
        trig_field_en_reg <= pwdata[`TCLS_BIT_FSWITCH];
      else if (pick_dec[1])
        snap_field_en_reg <= pwdata[`TCLS_BIT_FSWITCH];
    end
    if (wr_b2 && word_addr == `TCLS_OFF_CHUNK_CTRL)
      trig_enable_reg <= pwdata[`TCLS_BIT_TRIG_EN];
    if (wr_lo && word_addr == `TCLS_OFF_COUNT_CFG) begin
      count_slot_pick_reg <= pwdata[`TCLS_BIT_SLOT_HI:`TCLS_BIT_SLOT_LO];
      // only slot one owns the clear origin of the trigger count
      if (pwdata[`TCLS_BIT_SLOT_HI:`TCLS_BIT_SLOT_LO] == `TCLS_SLOT_TRIG)
        count_clear_origin_reg <= pwdata[`TCLS_BIT_ORIGIN_HI:`TCLS_BIT_ORIGIN_LO];
    end
    if (wr_b1 && word_addr == `TCLS_OFF_COUNT_CFG)
      count_event_origin_reg <= pwdata[`TCLS_BIT_EVENT_HI:`TCLS_BIT_EVENT_LO];
  end
end

////////////////////////////////////////////////////////////////////////////////
// chunk emitter: up to two fields per image through a two-entry buffer

localparam ST_IDLE = 2'd0;
localparam ST_TRIG = 2'd1;
localparam ST_SNAP = 2'd2;

reg [1:0] state_reg;
reg [1:0] state_next;
reg [31:0] buf_data0_reg;
reg [31:0] buf_data1_reg;
reg [1:0] buf_tag0_reg;
reg [1:0] buf_tag1_reg;
reg [1:0] buf_cnt_reg;
reg [31:0] cap_count_reg;
reg [31:0] cap_snap_reg;
reg push;
reg [31:0] push_data;
reg [1:0] push_tag;

// the emitter holds its push while both entries are full, so no word is lost
wire buf_ready = (buf_cnt_reg != 2'd2);
wire pop = field_valid & field_ready;
assign field_valid = (buf_cnt_reg != 2'd0);
assign field_data = buf_data0_reg;
assign field_tag = buf_tag0_reg;

always @* begin
  state_next = state_reg;
  push = 1'b0;
  push_data = cap_count_reg;
  push_tag = `TCLS_TAG_TRIG;
  case (state_reg)
    ST_IDLE: begin
      if (image_done && chunk_master_switch_reg) begin
        if (trig_field_en_reg && trig_enable_reg)
          state_next = ST_TRIG;
        else if (snap_field_en_reg)
          state_next = ST_SNAP;
      end
    end
    ST_TRIG: begin
      push = 1'b1;
      if (buf_ready)
        state_next = snap_field_en_reg ? ST_SNAP : ST_IDLE;
    end
    ST_SNAP: begin
      push = 1'b1;
      push_data = cap_snap_reg;
      push_tag = `TCLS_TAG_SNAP;
      if (buf_ready)
        state_next = ST_IDLE;
    end
    default: state_next = ST_IDLE;
  endcase
end

always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    state_reg <= ST_IDLE;
    cap_count_reg <= 32'h00000000;
    cap_snap_reg <= 32'h00000000;
    dropped_reg <= 1'b0;
  end else begin
    state_reg <= state_next;
    if (state_reg == ST_IDLE && image_done) begin
      cap_count_reg <= trigger_count_reg;
      cap_snap_reg <= line_snapshot_reg;
    end
    // an image ending while the emitter is still pushing the previous fields is dropped
    if (state_reg != ST_IDLE && image_done)
      dropped_reg <= 1'b1;
    // only a flag that the read actually returned is cleared
    else if (rd_en && word_addr == `TCLS_OFF_STATUS && prdata[0])
      dropped_reg <= 1'b0;
  end
end

always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    buf_cnt_reg <= 2'd0;
    buf_data0_reg <= 32'h00000000;
    buf_data1_reg <= 32'h00000000;
    buf_tag0_reg <= 2'h0;
    buf_tag1_reg <= 2'h0;
  end else begin
    // a push and a pop in one cycle keep the fill level
    if (push && buf_ready && pop) begin
      if (buf_cnt_reg == 2'd1) begin
        buf_data0_reg <= push_data;
        buf_tag0_reg <= push_tag;
      end else begin
        buf_data0_reg <= buf_data1_reg;
        buf_tag0_reg <= buf_tag1_reg;
        buf_data1_reg <= push_data;
        buf_tag1_reg <= push_tag;
      end
    end else if (push && buf_ready) begin
      if (buf_cnt_reg == 2'd0) begin
        buf_data0_reg <= push_data;
        buf_tag0_reg <= push_tag;
      end else begin
        buf_data1_reg <= push_data;
        buf_tag1_reg <= push_tag;
      end
      buf_cnt_reg <= buf_cnt_reg + 2'd1;
    end else if (pop) begin
      buf_data0_reg <= buf_data1_reg;
      buf_tag0_reg <= buf_tag1_reg;
      buf_cnt_reg <= buf_cnt_reg - 2'd1;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// read mux

// read data is taken at the setup edge so that it stands through the access phase
wire rd_setup = psel & ~penable & ~pwrite & addr_ok;
reg [31:0] rd_word;

always @* begin
  rd_word = 32'h00000000;
  case (word_addr)
    `TCLS_OFF_CHUNK_CTRL: begin
      rd_word[`TCLS_BIT_MASTER] = chunk_master_switch_reg;
      rd_word[`TCLS_BIT_PICK_HI:`TCLS_BIT_PICK_LO] = chunk_field_pick_reg;
      rd_word[`TCLS_BIT_FSWITCH] = (pick_dec[0] & trig_field_en_reg) |
        (pick_dec[1] & snap_field_en_reg);
      rd_word[`TCLS_BIT_TRIG_EN] = trig_enable_reg;
    end
    `TCLS_OFF_COUNT_CFG: begin
      rd_word[`TCLS_BIT_ORIGIN_HI:`TCLS_BIT_ORIGIN_LO] = count_clear_origin_reg;
      rd_word[`TCLS_BIT_SLOT_HI:`TCLS_BIT_SLOT_LO] = count_slot_pick_reg;
      rd_word[`TCLS_BIT_EVENT_HI:`TCLS_BIT_EVENT_LO] = count_event_origin_reg;
    end
    `TCLS_OFF_COUNT_VAL: rd_word = trig_enable_reg ? trigger_count_reg : 32'h00000000;
    `TCLS_OFF_SNAP_VAL: rd_word = line_snapshot_reg;
    `TCLS_OFF_FRAME_VAL: rd_word = frame_count_reg;
    `TCLS_OFF_STATUS: begin
      rd_word[0] = dropped_reg;
      rd_word[2:1] = buf_cnt_reg;
    end
    default: rd_word = 32'h00000000;
  endcase
end

// zero outside the access phase of a read, so stale words never linger on the bus
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    prdata <= 32'h00000000;
  end else if (rd_setup) begin
    prdata <= rd_word;
  end else begin
    prdata <= 32'h00000000;
  end
end

endmodule // tcls_trigger_chunks

// *** testbench/tcls_checker_properties.sv ***
// port-level assertions for the trigger count block
`timescale 1ns/1ps
module tcls_checker (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pslverr,
  input wire field_valid,
  input wire field_ready,
  input wire [31:0] field_data,
  input wire [1:0] field_tag
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc;
  assign acc = psel && penable;
  sequence word_waits;
    field_valid && !field_ready;
  endsequence
  sequence word_holds;
    field_valid && $stable(field_data) && $stable(field_tag);
  endsequence
  release_quiet_a: assert property ($rose(presetn) |-> !field_valid && prdata == 32'h0)
    else $error("output active after reset");
  misaligned_err_a: assert property (acc && paddr[1:0] != 2'h0 |-> pslverr && prdata == 32'h0)
    else $error("misaligned access not refused");
  unmapped_err_a: assert property (acc && paddr > 12'h018 |-> pslverr)
    else $error("unmapped access not refused");
  err_in_access_a: assert property (pslverr |-> acc)
    else $error("error outside access");
  cmd_reads_zero_a: assert property (acc && !pwrite && paddr == 12'h008 |-> prdata == 32'h0)
    else $error("command register read not zero");
  field_hold_a: assert property (word_waits |=> word_holds)
    else $error("field word changed while stalled");
  field_release_a: assert property ($fell(field_valid) |-> $past(field_ready))
    else $error("field word dropped without ready");
  field_tag_a: assert property (field_valid |-> field_tag <= 2'h1)
    else $error("bad field tag");
endmodule // tcls_checker
////////////////////////////////////////////////////////////////
bind tcls_trigger_chunks tcls_checker chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr),
  .field_valid(field_valid), .field_ready(field_ready), .field_data(field_data),
  .field_tag(field_tag));

// *** testbench/tcls_trig_src.sv ***
// external trigger source and first input pin model
`timescale 1ns/1ps
module tcls_trig_src (
  input wire pclk,
  input wire start,
  input wire [7:0] n,
  input wire [1:0] gap,
  input wire pin_req,
  output reg acquisition_trigger_event = 1'b0,
  output reg first_input_pin = 1'b0,
  output wire busy
);
  reg [7:0] left = 8'h00;
  reg [1:0] wt = 2'h0;
  assign busy = start || left != 8'h00;
  // gap 0 gives back-to-back triggers, larger gaps a slow source
  always @(posedge pclk) begin
    first_input_pin <= pin_req;
    acquisition_trigger_event <= 1'b0;
    if (start) begin
      left <= n;
      wt <= 2'h0;
    end else if (left != 8'h00) begin
      if (wt == 2'h0) begin
        acquisition_trigger_event <= 1'b1;
        left <= left - 8'h01;
        wt <= gap;
      end else begin
        wt <= wt - 2'h1;
      end
    end
  end
endmodule // tcls_trig_src

// *** testbench/tcls_trigger_chunks_test.sv ***
// self-checking bench for the trigger count and line snapshot block
`timescale 1ns/1ps
`define CK(a, e) begin checks++; if ((a) !== (e)) begin n_fail++; \
  $display("wrong value at %0t: got %h want %h", $time, a, e); end end
module tcls_trigger_chunks_test;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic bev = 0, img = 0, fv, fr = 0, start = 0, pin_req = 0, trig, pin, busy, in_l = 0;
  logic out_l = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd, prdata, fd;
  logic [3:0] pstrb = 4'hf;
  logic [7:0] n = 8'h00;
  logic [1:0] gap = 2'h0, ft;
  int n_fail = 0, checks = 0;
  logic [44:0] rows [9] = '{{12'h000, 32'h10000, 1'b0}, {12'h004, 32'h10, 1'b0},
    {12'h008, 32'h0, 1'b0}, {12'h00c, 32'h0, 1'b0}, {12'h010, 32'h0, 1'b0},
    {12'h014, 32'h0, 1'b0}, {12'h018, 32'h0, 1'b0}, {12'h01c, 32'h0, 1'b1},
    {12'h002, 32'h0, 1'b1}};
  logic [31:0] en [4] = '{32'h10001, 32'h10101, 32'h10111, 32'h10111};
  always #2.5 pclk = ~pclk;
  tcls_trigger_chunks uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .acquisition_trigger_event(trig),
    .acquisition_begin_event(bev), .first_input_pin(pin), .in_lines(in_l), .out_lines(out_l),
    .gpio_lines(1'b0), .image_done(img), .field_valid(fv), .field_ready(fr),
    .field_data(fd), .field_tag(ft));
  tcls_trig_src src (.pclk(pclk), .start(start), .n(n), .gap(gap), .pin_req(pin_req),
    .acquisition_trigger_event(trig), .first_input_pin(pin), .busy(busy));
  ////////////////////////////////////////////////////////////////
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1;
    @(posedge pclk);
    while (!pready) @(posedge pclk);
    rd = prdata; err = pslverr;
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask
  task chk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CK(rd, e)
  endtask
  task fire(input logic [7:0] k, input logic [1:0] g);
    n <= k; gap <= g; start <= 1;
    @(posedge pclk) start <= 0;
    @(posedge pclk);
    while (busy) @(posedge pclk);
    repeat (2) @(posedge pclk);
  endtask
  task pulse_img;
    img <= 1;
    @(posedge pclk) img <= 0;
    repeat (6) @(posedge pclk);
  endtask
  // sampled at the popping edge, before the buffer moves on
  task take(input logic [1:0] t, input logic [31:0] d);
    fr <= 1;
    @(posedge pclk);
    while (!fv) @(posedge pclk);
    `CK(ft, t)
    `CK(fd, d)
    fr <= 0;
    @(posedge pclk);
  endtask
  task close_out;
    $display("checks %0d, n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    #50us;
    n_fail++;
    close_out;
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    foreach (rows[i]) begin chk(rows[i][44:33], rows[i][32:1]); `CK(err, rows[i][0]) end
    in_l <= 1;
    fire(8'h03, 2'h0);
    chk(12'h00c, 32'h3);
    chk(12'h010, 32'h1);
    bev <= 1;
    @(posedge pclk) bev <= 0;
    chk(12'h014, 32'h1);
    in_l <= 0;
    out_l <= 1;
    fire(8'h01, 2'h2);
    chk(12'h010, 32'h2);
    apb(1'b1, 12'h000, 32'h10100);
    chk(12'h000, 32'h10000);
    foreach (en[i]) apb(1'b1, 12'h000, en[i]);
    chk(12'h000, 32'h10111);
    pulse_img;
    chk(12'h018, 32'h4);
    take(2'h0, 32'h4);
    take(2'h1, 32'h2);
    img <= 1;
    repeat (2) @(posedge pclk);
    img <= 0;
    repeat (6) @(posedge pclk);
    chk(12'h018, 32'h5);
    chk(12'h018, 32'h4);
    take(2'h0, 32'h4);
    take(2'h1, 32'h2);
    apb(1'b1, 12'h000, 32'h10000);
    apb(1'b1, 12'h000, 32'h10001);
    chk(12'h000, 32'h10001);
    pulse_img;
    `CK(fv, 1'b0)
    apb(1'b1, 12'h000, 32'h1);
    fire(8'h01, 2'h0);
    chk(12'h00c, 32'h0);
    apb(1'b1, 12'h000, 32'h10001);
    chk(12'h00c, 32'h4);
    apb(1'b1, 12'h008, 32'h1);
    chk(12'h00c, 32'h4);
    apb(1'b1, 12'h004, 32'h12);
    apb(1'b1, 12'h008, 32'h1);
    chk(12'h00c, 32'h0);
    fire(8'h01, 2'h0);
    chk(12'h00c, 32'h1);
    apb(1'b1, 12'h004, 32'h22);
    apb(1'b1, 12'h008, 32'h1);
    chk(12'h00c, 32'h1);
    apb(1'b1, 12'h004, 32'h11);
    pin_req <= 1;
    repeat (3) @(posedge pclk);
    chk(12'h00c, 32'h0);
    apb(1'b1, 12'h004, 32'h10);
    pin_req <= 0;
    fire(8'h01, 2'h0);
    pin_req <= 1;
    repeat (3) @(posedge pclk);
    chk(12'h00c, 32'h1);
    apb(1'b1, 12'h004, 32'h12);
    presetn <= 0;
    pin_req <= 0;
    repeat (5) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    chk(12'h00c, 32'h0);
    chk(12'h004, 32'h10);
    chk(12'h000, 32'h10000);
    close_out;
  end
endmodule // tcls_trigger_chunks_test
